// ### core/uaf_defs.vh
/*
 * Register map, field positions, reset values and modes of the dual-port
 * receive address filter.
 * Assumes a classic Wishbone slave with 32-bit data, byte addresses = word index * 4.
 */
// Contract
// (RULE_01) Framing check only in modes 1, 2, 3
// (RULE_02) Missing stop bit sets framing error flag
// (RULE_03) Control bit 7 selects mode bit or flag
// (RULE_04) Framing flag sticky, cleared only by software
// (RULE_05) Modes 2/3 with enable: ninth bit gates interrupt
// (RULE_06) Sender marks address bytes with ninth bit one
// (RULE_07) Mode 0 ignores multiprocessor enable
// (RULE_08) Mode 1 with enable needs valid stop
// (RULE_09) Enable set: receive flag only on match
// (RULE_10) Mode 1: stop bit acts as ninth bit
// (RULE_11) Given address is own AND mask
// (RULE_12) Broadcast address is own OR mask
// (RULE_13) Address and mask reset to zero
// (RULE_14) Port 1 has its own pair
// (RULE_15) Load only when flag clear and qualified
// (RULE_16) Match on Given or Broadcast address
`ifndef UAF_DEFS_VH
`define UAF_DEFS_VH

// ----------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------
`define UAF_IDX_U0_ADDR 8'ha9
`define UAF_IDX_U0_MASK 8'hb9
`define UAF_IDX_U1_MASK 8'hba
`define UAF_IDX_U1_ADDR 8'hbb
`define UAF_IDX_CTRL0 8'hc0
`define UAF_IDX_CTRL1 8'hc1
`define UAF_IDX_PWR 8'hc2
`define UAF_IDX_BUF0 8'hc3
`define UAF_IDX_BUF1 8'hc4
`define UAF_IDX_IRQ_STAT 8'hc5
`define UAF_IDX_IRQ_MASK 8'hc6

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define UAF_CTL_RX_FLAG 0
`define UAF_CTL_NINTH 2
`define UAF_CTL_MP_EN 5
`define UAF_CTL_MODE_LO 6
`define UAF_CTL_MODE_HI 7
`define UAF_PWR_FE_SEL 6
`define UAF_RST_BYTE 8'h00
`define UAF_IRQ_RX0 0
`define UAF_IRQ_RX1 1
`define UAF_IRQ_FE0 2
`define UAF_IRQ_FE1 3

`endif

// ### core/uaf_filter.v
/*
 * Receive qualification for two serial ports: framing error flags,
 * multiprocessor ninth-bit filtering and hardware address recognition,
 * with a Wishbone classic register file and one level interrupt.
 * Assumes the receive shifters deliver a one-cycle frame-done pulse with
 * data, ninth bit and stop validity, all in the CLOCK domain.
 */
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
`include "uaf_defs.vh"

module uaf_filter (
    input wire CLOCK,
    input wire RST,
    input wire [7:0] WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    input wire [3:0] WB_SEL_I,
    input wire WB_WE_I,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    output reg [31:0] WB_DAT_O,
    output reg WB_ACK_O,
    input wire [1:0] RX_DONE,
    input wire [15:0] RX_DATA,
    input wire [1:0] RX_NINTH,
    input wire [1:0] RX_STOP_OK,
    output reg [1:0] RX_ACCEPT,
    output reg IRQ
);

    // ----------------------------------------------------------------
    // Address recognition
    // ----------------------------------------------------------------
    // Given: own&mask cares where mask=1; broadcast: own|mask cares where 1
    function addr_match;
        input [7:0] rx;
        input [7:0] own;
        input [7:0] msk;
        reg [7:0] given;
        reg [7:0] bcast;
        begin
            given = own & msk; // [RULE_11]
            bcast = own | msk; // [RULE_12]
            addr_match = (((rx ^ given) & msk) == 8'h00) || // [RULE_16]
                         (((rx ^ bcast) & bcast) == 8'h00);
        end
    endfunction

    // Decides whether a finished frame loads the port
    function frame_ok;
        input [7:0] ctl;
        input [7:0] rx;
        input ninth;
        input stop_ok;
        input [7:0] own;
        input [7:0] msk;
        reg [1:0] mode;
        reg ninth_eff;
        begin
            mode = {ctl[`UAF_CTL_MODE_HI], ctl[`UAF_CTL_MODE_LO]};
            // Mode 1 has no ninth bit; the stop bit stands in for it
            ninth_eff = (mode == 2'd1) ? stop_ok : ninth; // [RULE_10] [RULE_08]
            if (ctl[`UAF_CTL_RX_FLAG])
                frame_ok = 1'b0; // [RULE_15]
            else if (mode == 2'd0 || !ctl[`UAF_CTL_MP_EN])
                frame_ok = 1'b1; // [RULE_07]
            else
                frame_ok = ninth_eff && addr_match(rx, own, msk); // [RULE_05] [RULE_09]
        end
    endfunction

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    reg [7:0] u0_addr_r;
    reg [7:0] u0_mask_r;
    reg [7:0] u1_addr_r;
    reg [7:0] u1_mask_r;
    reg [7:0] ctl0_r;
    reg [7:0] ctl1_r;
    reg [7:0] pwr_r;
    reg [1:0] fe_r;
    reg [7:0] buf0_r;
    reg [7:0] buf1_r;
    reg [3:0] irq_stat_r;
    reg [3:0] irq_mask_r;

    wire req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    wire wr = req && WB_WE_I && WB_SEL_I[0];
    wire [7:0] wd = WB_DAT_I[7:0];
    wire fe_sel = pwr_r[`UAF_PWR_FE_SEL];
    wire wr_ctl0 = wr && WB_ADR_I == `UAF_IDX_CTRL0;
    wire wr_ctl1 = wr && WB_ADR_I == `UAF_IDX_CTRL1;
    wire wr_stat = wr && WB_ADR_I == `UAF_IDX_IRQ_STAT;
    wire [1:0] load;
    wire [1:0] fe_evt;

    assign load[0] = RX_DONE[0] && frame_ok(ctl0_r, RX_DATA[7:0], RX_NINTH[0], RX_STOP_OK[0], u0_addr_r, u0_mask_r);
    assign load[1] = RX_DONE[1] && frame_ok(ctl1_r, RX_DATA[15:8], RX_NINTH[1], RX_STOP_OK[1], u1_addr_r, u1_mask_r);
    // Framing check skipped in mode 0, which has no stop bit
    assign fe_evt[0] = RX_DONE[0] && !RX_STOP_OK[0] && // [RULE_01] [RULE_02]
                       ({ctl0_r[`UAF_CTL_MODE_HI], ctl0_r[`UAF_CTL_MODE_LO]} != 2'd0);
    assign fe_evt[1] = RX_DONE[1] && !RX_STOP_OK[1] &&
                       ({ctl1_r[`UAF_CTL_MODE_HI], ctl1_r[`UAF_CTL_MODE_LO]} != 2'd0);

    // ----------------------------------------------------------------
    // Register writes and frame loading
    // ----------------------------------------------------------------
    // Hardware set beats software clear on every flag
    always @(posedge CLOCK) begin
        if (RST) begin
            u0_addr_r <= `UAF_RST_BYTE; // [RULE_13]
            u0_mask_r <= `UAF_RST_BYTE;
            u1_addr_r <= `UAF_RST_BYTE; // [RULE_14]
            u1_mask_r <= `UAF_RST_BYTE;
            ctl0_r <= `UAF_RST_BYTE;
            ctl1_r <= `UAF_RST_BYTE;
            pwr_r <= `UAF_RST_BYTE;
            fe_r <= 2'b00;
            buf0_r <= `UAF_RST_BYTE;
            buf1_r <= `UAF_RST_BYTE;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
        end else begin
            if (wr && WB_ADR_I == `UAF_IDX_U0_ADDR) u0_addr_r <= wd;
            if (wr && WB_ADR_I == `UAF_IDX_U0_MASK) u0_mask_r <= wd;
            if (wr && WB_ADR_I == `UAF_IDX_U1_ADDR) u1_addr_r <= wd;
            if (wr && WB_ADR_I == `UAF_IDX_U1_MASK) u1_mask_r <= wd;
            if (wr && WB_ADR_I == `UAF_IDX_PWR) pwr_r <= wd;
            if (wr && WB_ADR_I == `UAF_IDX_IRQ_MASK) irq_mask_r <= wd[3:0];
            // Bit 7 goes to the mode bit or the flag per the select
            if (wr_ctl0) begin
                ctl0_r[6:0] <= wd[6:0];
                if (!fe_sel) ctl0_r[7] <= wd[7]; // [RULE_03]
            end
            if (wr_ctl1) begin
                ctl1_r[6:0] <= wd[6:0];
                if (!fe_sel) ctl1_r[7] <= wd[7];
            end
            // Flag survives good frames; only a software write clears it
            fe_r[0] <= fe_evt[0] | ((wr_ctl0 && fe_sel) ? wd[7] : fe_r[0]); // [RULE_04]
            fe_r[1] <= fe_evt[1] | ((wr_ctl1 && fe_sel) ? wd[7] : fe_r[1]);
            if (load[0]) begin
                buf0_r <= RX_DATA[7:0]; // [RULE_15]
                ctl0_r[`UAF_CTL_NINTH] <= RX_NINTH[0];
                ctl0_r[`UAF_CTL_RX_FLAG] <= 1'b1;
            end
            if (load[1]) begin
                buf1_r <= RX_DATA[15:8];
                ctl1_r[`UAF_CTL_NINTH] <= RX_NINTH[1];
                ctl1_r[`UAF_CTL_RX_FLAG] <= 1'b1;
            end
            irq_stat_r <= (irq_stat_r & ~(wr_stat ? wd[3:0] : 4'h0)) | {fe_evt, load};
        end
    end

    // ----------------------------------------------------------------
    // Bus answer and outputs
    // ----------------------------------------------------------------
    // One registered answer, acked the cycle after the strobe; unmapped reads return zero
    always @(posedge CLOCK) begin
        if (RST) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h0;
            RX_ACCEPT <= 2'b00;
            IRQ <= 1'b0;
        end else begin
            WB_ACK_O <= req;
            RX_ACCEPT <= load;
            IRQ <= |(irq_stat_r & irq_mask_r);
            WB_DAT_O <= 32'h0;
            if (req && !WB_WE_I) begin
                case (WB_ADR_I)
                    `UAF_IDX_U0_ADDR: WB_DAT_O <= {24'h0, u0_addr_r};
                    `UAF_IDX_U0_MASK: WB_DAT_O <= {24'h0, u0_mask_r};
                    `UAF_IDX_U1_ADDR: WB_DAT_O <= {24'h0, u1_addr_r};
                    `UAF_IDX_U1_MASK: WB_DAT_O <= {24'h0, u1_mask_r};
                    `UAF_IDX_CTRL0: WB_DAT_O <= {24'h0, fe_sel ? fe_r[0] : ctl0_r[7], ctl0_r[6:0]}; // [RULE_03]
                    `UAF_IDX_CTRL1: WB_DAT_O <= {24'h0, fe_sel ? fe_r[1] : ctl1_r[7], ctl1_r[6:0]};
                    `UAF_IDX_PWR: WB_DAT_O <= {24'h0, pwr_r};
                    `UAF_IDX_BUF0: WB_DAT_O <= {24'h0, buf0_r};
                    `UAF_IDX_BUF1: WB_DAT_O <= {24'h0, buf1_r};
                    `UAF_IDX_IRQ_STAT: WB_DAT_O <= {28'h0, irq_stat_r};
                    `UAF_IDX_IRQ_MASK: WB_DAT_O <= {28'h0, irq_mask_r};
                    default: WB_DAT_O <= 32'h0;
                endcase
            end
        end
    end

endmodule // uaf_filter

// ### test/uaf_filter_asserts.sv
/* Port checker for the receive filter.
   Assumes a bind onto uaf_filter, one clock domain. */
`timescale 1ns/1ps
module uaf_chk (
    input wire CLOCK,
    input wire RST,
    input wire WB_CYC_I,
    input wire WB_STB_I,
    input wire [31:0] WB_DAT_O,
    input wire WB_ACK_O,
    input wire [1:0] RX_DONE,
    input wire [1:0] RX_ACCEPT,
    input wire IRQ
);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    // Bus answer timing and read data framing
    a_ack_next: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing");
    a_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack held");
    a_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
        else $error("data without ack");
    a_dat_upper: assert property (WB_ACK_O |-> WB_DAT_O[31:8] == 24'h0)
        else $error("upper bits set");
    // A load needs a frame the cycle before, one port each
    a_load0_cause: assert property (RX_ACCEPT[0] |-> $past(RX_DONE[0]))
        else $error("port0 load without frame");
    a_load1_cause: assert property (RX_ACCEPT[1] |-> $past(RX_DONE[1]))
        else $error("port1 load without frame");
    a_load_once: assert property (RX_ACCEPT[0] |=> !RX_ACCEPT[0])
        else $error("load while flag set");
    a_reset_quiet: assert property ($past(RST) |-> !IRQ && RX_ACCEPT == 2'b00)
        else $error("outputs busy after reset");
endmodule // uaf_chk

// ### test/uaf_node.sv
/* Far-side serial node: hands finished frames to the filter.
   Assumes the filter takes a frame on the edge where done is high. */
`timescale 1ns/1ps
module uaf_node (
    input wire clock,
    output reg [1:0] done,
    output reg [15:0] data,
    output reg [1:0] ninth,
    output reg [1:0] stop_ok
);
    initial {done, data, ninth, stop_ok} = 22'h0;
    // One frame; address bytes carry ninth bit one, data bytes zero
    task send(input int p, input [7:0] b, input n9, input st);
        @(posedge clock);
        {done[p], ninth[p], stop_ok[p]} <= {1'b1, n9, st};
        data[p*8 +: 8] <= b;
        @(posedge clock);
        // Released lines show inverted junk, never the old value
        {done[p], ninth[p], stop_ok[p]} <= {1'b0, ~n9, ~st};
        data[p*8 +: 8] <= ~b;
    endtask
endmodule // uaf_node

// ### test/uaf_filter_test.sv
/* Register and frame tests of the filter.
   Assumes uaf_defs.vh on the include path. */
`timescale 1ns/1ps
`include "uaf_defs.vh"
module uaf_filter_test;
    reg clock = 0, rst = 1, cyc = 0, stb = 0, we = 0;
    reg [7:0] adr = 0;
    reg [31:0] wdat = 0, q;
    wire [31:0] rdat;
    wire ack, irq;
    wire [1:0] done, ninth, stop_ok, accept;
    wire [15:0] data;
    integer fails = 0, n_checks = 0, i;
    reg [7:0] idx [4] = '{`UAF_IDX_U0_ADDR, `UAF_IDX_U0_MASK, `UAF_IDX_U1_MASK, `UAF_IDX_U1_ADDR};
    uaf_filter i_uaf_filter (.CLOCK(clock), .RST(rst), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(4'h1),
        .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat), .WB_ACK_O(ack), .RX_DONE(done),
        .RX_DATA(data), .RX_NINTH(ninth), .RX_STOP_OK(stop_ok), .RX_ACCEPT(accept), .IRQ(irq));
    uaf_node i_uaf_node (.clock(clock), .done(done), .data(data), .ninth(ninth), .stop_ok(stop_ok));
    initial forever #4 clock = ~clock;
    task check(input [31:0] seen, input [31:0] exp);
        n_checks = n_checks + 1;
        if (seen !== exp) begin
            fails = fails + 1;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task test_done;
        if (fails == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Classic single cycle; bounded wait so a dead slave cannot hang us
    task wb(input w, input [7:0] a, input [7:0] d);
        integer n;
        @(posedge clock);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, 24'h0, d};
        n = 0;
        do begin
            @(posedge clock);
            n = n + 1;
        end while (ack !== 1'b1 && n < 20);
        // Judge by ack itself so an answer on the last try still counts
        if (ack !== 1'b1) begin
            fails = fails + 1;
            test_done;
        end else begin
            q = rdat;
            {cyc, stb} <= 2'b00;
        end
    endtask
    task rd(input [7:0] a, input [7:0] e);
        wb(0, a, 0);
        check(q, {24'h0, e});
    endtask
    task rx(input int p, input [7:0] b, input n9, input st, input acc);
        i_uaf_node.send(p, b, n9, st);
        #1;
        check(accept[p], acc);
    endtask
    task fe(input exp);
        wb(1, `UAF_IDX_PWR, 8'h40);
        wb(0, `UAF_IDX_CTRL0, 0);
        check(q[7], exp);
        wb(1, `UAF_IDX_PWR, 0);
    endtask
    initial begin
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        for (i = 0; i < 4; i++) rd(idx[i], 8'h00);
        rd(8'h10, 8'h00);
        wb(1, `UAF_IDX_U0_ADDR, 8'hc0);
        wb(1, `UAF_IDX_U0_MASK, 8'hfd);
        rd(`UAF_IDX_U0_MASK, 8'hfd);
        wb(1, `UAF_IDX_IRQ_MASK, 8'h01);
        wb(1, `UAF_IDX_CTRL0, 8'ha0);
        wb(1, `UAF_IDX_CTRL1, 8'ha0);
        // Mode 2 with filtering on: given, broadcast and data bytes
        rx(0, 8'hc2, 1, 1, 1);
        rd(`UAF_IDX_CTRL0, 8'ha5);
        rd(`UAF_IDX_BUF0, 8'hc2);
        @(posedge clock);
        #1 check(irq, 1);
        wb(1, `UAF_IDX_IRQ_STAT, 8'h01);
        #1 check(irq, 0);
        rx(0, 8'hc2, 1, 1, 0);
        wb(1, `UAF_IDX_CTRL0, 8'ha0);
        rx(0, 8'hc1, 1, 1, 0);
        rx(0, 8'hff, 1, 1, 1);
        wb(1, `UAF_IDX_CTRL0, 8'ha0);
        rx(0, 8'hc2, 0, 1, 0);
        rx(1, 8'hc1, 1, 1, 1);
        rd(`UAF_IDX_BUF1, 8'hc1);
        // Port 1 gets its own pair: c2 suits port 0 but not this one
        wb(1, `UAF_IDX_U1_ADDR, 8'hc0);
        wb(1, `UAF_IDX_U1_MASK, 8'hfe);
        wb(1, `UAF_IDX_CTRL1, 8'ha0);
        rx(1, 8'hc2, 1, 1, 0);
        rx(1, 8'hc1, 1, 1, 1);
        // Framing flag in mode 1, sticky across a good frame
        wb(1, `UAF_IDX_CTRL0, 8'h40);
        rx(0, 8'h33, 0, 0, 1);
        wb(1, `UAF_IDX_CTRL0, 8'h40);
        rx(0, 8'h34, 0, 1, 1);
        fe(1);
        wb(0, `UAF_IDX_CTRL0, 0);
        check(q[7], 0);
        // Load status of port 0 is still pending and unmasked
        check(irq, 1);
        rd(`UAF_IDX_IRQ_STAT, 8'h07);
        wb(1, `UAF_IDX_IRQ_STAT, 8'h0f);
        #1 check(irq, 0);
        wb(1, `UAF_IDX_PWR, 8'h40);
        wb(1, `UAF_IDX_CTRL0, 8'h40);
        fe(0);
        // Mode 0 ignores the enable and never flags framing; mode 1 with enable needs a good stop and a match
        wb(1, `UAF_IDX_CTRL0, 8'h20);
        rx(0, 8'hc1, 0, 0, 1);
        fe(0);
        wb(1, `UAF_IDX_CTRL0, 8'h60);
        rx(0, 8'hc2, 0, 0, 0);
        rx(0, 8'hc1, 0, 1, 0);
        rx(0, 8'hc2, 0, 1, 1);
        // Mode 3 filters on the ninth bit like mode 2
        wb(1, `UAF_IDX_CTRL0, 8'he0);
        rx(0, 8'hc0, 0, 1, 0);
        rx(0, 8'hc0, 1, 1, 1);
        test_done;
    end
endmodule // uaf_filter_test
bind uaf_filter uaf_chk i_uaf_chk (.CLOCK(CLOCK), .RST(RST), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .RX_DONE(RX_DONE), .RX_ACCEPT(RX_ACCEPT), .IRQ(IRQ));
